//--- hw/stwc_consts.svh
// register map, reset values, mode codes and timing counts of the timer
`ifndef STWC_CONSTS_SVH
`define STWC_CONSTS_SVH
// i/o register addresses
`define STWC_ADDR_TIFR     6'h0b
`define STWC_ADDR_FORCE    6'h22
`define STWC_ADDR_ICR_L    6'h24
`define STWC_ADDR_ICR_H    6'h25
`define STWC_ADDR_OCRB_L   6'h28
`define STWC_ADDR_OCRB_H   6'h29
`define STWC_ADDR_OCRA_L   6'h2a
`define STWC_ADDR_OCRA_H   6'h2b
`define STWC_ADDR_CNT_L    6'h2c
`define STWC_ADDR_CNT_H    6'h2d
`define STWC_ADDR_CTL_B    6'h2e
`define STWC_ADDR_CTL_A    6'h2f
// reset values and field layout
`define STWC_RST_BYTE      8'h00
`define STWC_RST_WORD      16'h0000
`define STWC_CTL_B_MASK    8'hdf
`define STWC_BIT_FORCE_A   7
`define STWC_BIT_FORCE_B   6
// fixed tops
`define STWC_TOP_MAX       16'hffff
`define STWC_TOP_8BIT      16'h00ff
`define STWC_TOP_9BIT      16'h01ff
`define STWC_TOP_10BIT     16'h03ff
// waveform mode codes
`define STWC_MODE_NORMAL   4'h0
`define STWC_MODE_CTC_OCR  4'h4
`define STWC_MODE_PFC_ICR  4'h8
`define STWC_MODE_PFC_OCR  4'h9
`define STWC_MODE_PC_ICR   4'ha
`define STWC_MODE_CTC_ICR  4'hc
`define STWC_MODE_RESERVED 4'hd
`define STWC_MODE_FAST_ICR 4'he
// prescaler tap masks (tick when masked bits are all ones)
`define STWC_PRE_DIV8      10'h007
`define STWC_PRE_DIV64     10'h03f
`define STWC_PRE_DIV256    10'h0ff
`define STWC_PRE_DIV1024   10'h3ff
// capture noise filter length in clock cycles
`define STWC_FILT_LEN      4
`endif

//--- hw/stwc_pkg.sv
// state types of the sixteen-bit timer
package stwc_pkg;
   typedef struct packed {
      logic [7:0]       ctl_a;
      logic [7:0]       ctl_b;
      logic [15:0]      cnt;
      logic             dir_down;
      logic [1:0][15:0] ocr_buf;
      logic [1:0][15:0] ocr_act;
      logic [15:0]      icr;
      logic [7:0]       temp;
      logic [3:0]       flag;     // {capture, match b, match a, overflow}
      logic             blk;
      logic [1:0]       wave;
      logic [7:0]       rdata;
   } stwc_main_t;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic [9:0] pre;
   } stwc_clk_t;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic [3:0] hist;
      logic       filt;
      logic       prev;
   } stwc_cap_t;
endpackage

//--- hw/stwc_evt_if.sv
// control and event signals between the timer core and its input stages
`timescale 1ns/1ps
interface stwc_evt_if;
   logic [2:0] clock_source_sel;
   logic       capture_noise_filter_en;
   logic       capture_edge_sel;
   logic       capture_en;
   logic       count_tick;
   logic       capture_evt;
   modport core (output clock_source_sel, capture_noise_filter_en,
                 capture_edge_sel, capture_en,
                 input count_tick, capture_evt);
   modport clk_src (input clock_source_sel, output count_tick);
   modport cap (input capture_noise_filter_en, capture_edge_sel,
                capture_en, output capture_evt);
endinterface

//--- hw/stwc_clk_src.sv
// clock select: free prescaler taps and synchronised external count pin
`timescale 1ns/1ps
`include "stwc_consts.svh"
module stwc_clk_src
   import stwc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic external_count_pin,
   stwc_evt_if.clk_src ev
);
   stwc_clk_t q;
   stwc_clk_t d;

   // prescaler free runs, so the first prescaled tick lands 1..n cycles late
   always_comb
   begin
      d     = q;
      d.s1  = external_count_pin;
      d.s2  = q.s1;
      d.s3  = q.s2;
      d.pre = 10'(q.pre + 10'h001);
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= d;
   end

   // pin edges are counted even when the pin is driven as an output
   always_comb
   begin
      unique case (ev.clock_source_sel)
         3'h0: ev.count_tick = 1'b0;
         3'h1: ev.count_tick = 1'b1;
         3'h2: ev.count_tick = &(q.pre | ~`STWC_PRE_DIV8);
         3'h3: ev.count_tick = &(q.pre | ~`STWC_PRE_DIV64);
         3'h4: ev.count_tick = &(q.pre | ~`STWC_PRE_DIV256);
         3'h5: ev.count_tick = &q.pre;
         3'h6: ev.count_tick = q.s3 & ~q.s2;
         3'h7: ev.count_tick = ~q.s3 & q.s2;
      endcase
   end
endmodule

//--- hw/stwc_capture.sv
// capture input: synchroniser, optional noise filter, edge select
`timescale 1ns/1ps
`include "stwc_consts.svh"
module stwc_capture
   import stwc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic capture_input_pin,
   stwc_evt_if.cap   ev
);
   stwc_cap_t q;
   stwc_cap_t d;
   logic      sig;

   // filter output moves only after four equal samples in a row
   always_comb
   begin
      d      = q;
      d.s1   = capture_input_pin;
      d.s2   = q.s1;
      d.hist = {q.hist[2:0], q.s2};
      if ((&q.hist || ~|q.hist) && (q.hist[0] != q.filt))
         d.filt = q.hist[0];
      d.prev = sig;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= d;
   end

   assign sig = ev.capture_noise_filter_en ? q.filt : q.s2;
   // disconnected input never fires, even across a mode change
   assign ev.capture_evt = ev.capture_en &&
      (ev.capture_edge_sel ? (sig & ~q.prev) : (~sig & q.prev));

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_filter_needs_run: assert property ($changed(q.filt) |->
      $past(q.hist) == {`STWC_FILT_LEN{q.filt}})
      else $error("filter output moved without four equal samples");
endmodule

//--- hw/stwc_timer.sv
// sixteen-bit timer/counter with waveform modes and input capture
// Notes on behaviour
// - four-bit mode from two bits of each control register; 1101 reserved
// - mode 0000 counts to 0xFFFF, compares apply at once, overflow at max
// - phase-correct: fixed or capture/compare-a top, update at top
// - fast pwm: fixed or capture/compare-a top, update and overflow at top
// - clear-on-compare top from compare a or capture, immediate, max flag
// - phase-and-frequency-correct top capture or a, update/flag at bottom
// - noise filter needs four equal samples before the input changes
// - edge select zero captures falling, one captures rising edges
// - capture copies counter into capture register and sets capture flag
// - capture input is disconnected when capture register is top
// - clock select: stop, divide 1/8/64/256/1024, external fall/rise
// - external pin edges count even when the pin is an output
// - force bit causes an immediate compare action in non-pwm modes
// - forced compare sets no flag and never clears the counter
// - force bits are write-only strobes and read as zero
// - sixteen-bit access through one shared eight-bit high-byte latch
// - a counter write blocks compare matches on the next timer tick
// - both compare registers are compared with the counter continuously
// - match flag is set in the tick after counter equals compare
// - flags clear on vector acknowledge or on a written one
`timescale 1ns/1ps
`include "stwc_consts.svh"
module stwc_timer
   import stwc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [5:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   input  wire logic [3:0] flag_ack,
   input  wire logic       external_count_pin,
   input  wire logic       capture_input_pin,
   output logic            waveform_out_a,
   output logic            waveform_out_b,
   output logic            waveform_en_a,
   output logic            waveform_en_b,
   output logic            capture_flag,
   output logic            compare_match_flag_b,
   output logic            compare_match_flag_a,
   output logic            overflow_flag
);
   stwc_main_t q;
   stwc_main_t d;
   stwc_evt_if ev ();

   logic [3:0]  waveform_mode_sel;
   logic [15:0] top;
   logic        non_pwm;
   logic        fast;
   logic        icr_top;
   logic        upd_bottom;
   logic        at_top;
   logic        at_bot;
   logic        tick;
   logic        upd_now;
   logic [1:0]  match;
   logic [1:0]  force_cmp;
   logic [3:0]  fset;
   logic [3:0]  fclr;
   logic [1:0]  com;
   logic        do_act;

   stwc_clk_src u_clk_src (
      .clk                (clk),
      .rst_b              (rst_b),
      .external_count_pin (external_count_pin),
      .ev                 (ev.clk_src)
   );

   stwc_capture u_capture (
      .clk               (clk),
      .rst_b             (rst_b),
      .capture_input_pin (capture_input_pin),
      .ev                (ev.cap)
   );

   // mode decode from both control registers
   assign waveform_mode_sel = {q.ctl_b[4:3], q.ctl_a[1:0]};
   assign icr_top = waveform_mode_sel == `STWC_MODE_PFC_ICR ||
                    waveform_mode_sel == `STWC_MODE_PC_ICR  ||
                    waveform_mode_sel == `STWC_MODE_CTC_ICR ||
                    waveform_mode_sel == `STWC_MODE_FAST_ICR;
   // reserved code runs as plain counting so the timer never locks up
   assign non_pwm = waveform_mode_sel == `STWC_MODE_NORMAL  ||
                    waveform_mode_sel == `STWC_MODE_CTC_OCR ||
                    waveform_mode_sel == `STWC_MODE_CTC_ICR ||
                    waveform_mode_sel == `STWC_MODE_RESERVED;
   assign fast = (waveform_mode_sel[2:0] > 3'h4 && !waveform_mode_sel[3]) ||
                 waveform_mode_sel == `STWC_MODE_FAST_ICR ||
                 waveform_mode_sel == 4'hf;
   assign upd_bottom = waveform_mode_sel == `STWC_MODE_PFC_ICR ||
                       waveform_mode_sel == `STWC_MODE_PFC_OCR;

   // top source per mode
   always_comb
   begin
      unique case (waveform_mode_sel)
         4'h1, 4'h5:                top = `STWC_TOP_8BIT;
         4'h2, 4'h6:                top = `STWC_TOP_9BIT;
         4'h3, 4'h7:                top = `STWC_TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf:    top = q.ocr_act[0];
         4'h8, 4'ha, 4'hc, 4'he:    top = q.icr;
         4'h0, 4'hd:                top = `STWC_TOP_MAX;
      endcase
   end

   assign tick    = ev.count_tick;
   assign at_top  = q.cnt == top;
   assign at_bot  = q.cnt == `STWC_RST_WORD;
   assign upd_now = tick && (upd_bottom ? (at_bot && q.dir_down) : at_top);

   // controls handed to the input stages
   assign ev.clock_source_sel        = q.ctl_b[2:0];
   assign ev.capture_noise_filter_en = q.ctl_b[7];
   assign ev.capture_edge_sel        = q.ctl_b[6];
   assign ev.capture_en              = !icr_top;

   // force strobes only act in non-pwm modes; they are never stored
   assign force_cmp = (io_wr && io_addr == `STWC_ADDR_FORCE && non_pwm) ?
      {io_wdata[`STWC_BIT_FORCE_B], io_wdata[`STWC_BIT_FORCE_A]} : 2'b00;
   // a counter write removes the match on the following tick
   assign match[0] = tick && !q.blk && q.cnt == q.ocr_act[0];
   assign match[1] = tick && !q.blk && q.cnt == q.ocr_act[1];

   always_comb
   begin
      d      = q;
      fset   = 4'h0;
      fclr   = flag_ack;
      com    = 2'b00;
      do_act = 1'b0;
      // counting sequence
      if (tick)
      begin
         d.blk = 1'b0;
         if (non_pwm || fast)
         begin
            if (at_top && waveform_mode_sel != `STWC_MODE_NORMAL)
               d.cnt = `STWC_RST_WORD;
            else
               d.cnt = 16'(q.cnt + 16'h0001);
         end
         else if (!q.dir_down)
         begin
            if (q.cnt >= top)
            begin
               d.dir_down = 1'b1;
               d.cnt      = 16'(q.cnt - 16'h0001);
            end
            else
               d.cnt = 16'(q.cnt + 16'h0001);
         end
         else if (at_bot)
         begin
            d.dir_down = 1'b0;
            d.cnt      = 16'(q.cnt + 16'h0001);
         end
         else
            d.cnt = 16'(q.cnt - 16'h0001);
         // overflow point per mode
         if (non_pwm)
            fset[0] = q.cnt == `STWC_TOP_MAX;
         else if (fast)
            fset[0] = at_top;
         else
            fset[0] = at_bot && q.dir_down;
         // reaching top sets the capture flag when capture register is top
         fset[3] = icr_top && at_top;
         fset[2:1] = match;
      end
      // buffered compare values move over at the update point
      if (upd_now && !non_pwm)
         d.ocr_act = q.ocr_buf;
      // waveform action per channel
      for (int i = 0; i < 2; i++)
      begin
         com    = (i == 0) ? q.ctl_a[7:6] : q.ctl_a[5:4];
         do_act = match[i] || force_cmp[i];
         if (non_pwm && do_act)
         begin
            unique case (com)
               2'b01: d.wave[i] = ~q.wave[i];
               2'b10: d.wave[i] = 1'b0;
               2'b11: d.wave[i] = 1'b1;
               2'b00: d.wave[i] = q.wave[i];
            endcase
         end
         else if (fast && tick)
         begin
            if (at_top && com[1])
               d.wave[i] = ~com[0];   // set at bottom when non-inverting
            else if (match[i] && q.ocr_act[i] != top)
               d.wave[i] = com[1] ? com[0] :
                  ((i == 0 && waveform_mode_sel[3] && com[0]) ?
                   ~q.wave[i] : q.wave[i]);
         end
         else if (!non_pwm && !fast && match[i])
         begin
            if (com[1])
               d.wave[i] = com[0] ^ q.dir_down;
            else if (i == 0 && waveform_mode_sel[3] && com[0])
               d.wave[i] = ~q.wave[i];
         end
      end
      // capture of the counter value
      if (ev.capture_evt)
      begin
         d.icr   = q.cnt;
         fset[3] = 1'b1;
      end
      // bus writes; counter write after counting so it wins
      if (io_wr)
      begin
         unique case (io_addr)
            `STWC_ADDR_CTL_A: d.ctl_a = io_wdata;
            `STWC_ADDR_CTL_B: d.ctl_b = io_wdata & `STWC_CTL_B_MASK;
            `STWC_ADDR_CNT_H, `STWC_ADDR_OCRA_H, `STWC_ADDR_OCRB_H,
            `STWC_ADDR_ICR_H: d.temp = io_wdata;
            `STWC_ADDR_CNT_L:
            begin
               d.cnt = {q.temp, io_wdata};
               d.blk = 1'b1;
            end
            `STWC_ADDR_OCRA_L:
            begin
               d.ocr_buf[0] = {q.temp, io_wdata};
               if (non_pwm)
                  d.ocr_act[0] = {q.temp, io_wdata};
            end
            `STWC_ADDR_OCRB_L:
            begin
               d.ocr_buf[1] = {q.temp, io_wdata};
               if (non_pwm)
                  d.ocr_act[1] = {q.temp, io_wdata};
            end
            `STWC_ADDR_ICR_L: d.icr = {q.temp, io_wdata};
            `STWC_ADDR_TIFR:
               fclr = fclr | {io_wdata[5], io_wdata[2:0]};
            default: ;
         endcase
      end
      // hardware set wins over a clear in the same cycle
      d.flag = (q.flag & ~fclr) | fset;
      // reads answer one cycle later; counter or capture low byte read loads the latch
      d.rdata = `STWC_RST_BYTE;
      if (io_rd)
      begin
         unique case (io_addr)
            `STWC_ADDR_CTL_A:  d.rdata = q.ctl_a;
            `STWC_ADDR_CTL_B:  d.rdata = q.ctl_b;
            `STWC_ADDR_FORCE:  d.rdata = `STWC_RST_BYTE;
            `STWC_ADDR_CNT_L:
            begin
               d.rdata = q.cnt[7:0];
               d.temp  = q.cnt[15:8];
            end
            `STWC_ADDR_ICR_L:
            begin
               d.rdata = q.icr[7:0];
               d.temp  = q.icr[15:8];
            end
            `STWC_ADDR_CNT_H, `STWC_ADDR_ICR_H: d.rdata = q.temp;
            `STWC_ADDR_OCRA_L: d.rdata = q.ocr_buf[0][7:0];
            `STWC_ADDR_OCRA_H: d.rdata = q.ocr_buf[0][15:8];
            `STWC_ADDR_OCRB_L: d.rdata = q.ocr_buf[1][7:0];
            `STWC_ADDR_OCRB_H: d.rdata = q.ocr_buf[1][15:8];
            `STWC_ADDR_TIFR:
               d.rdata = {2'b00, q.flag[3], 2'b00, q.flag[2:0]};
            default: d.rdata = `STWC_RST_BYTE;
         endcase
      end
   end

   // whole state clears on reset: stopped, no clock source
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= d;
   end

   assign io_rdata             = q.rdata;
   assign waveform_out_a       = q.wave[0];
   assign waveform_out_b       = q.wave[1];
   assign waveform_en_a        = |q.ctl_a[7:6];
   assign waveform_en_b        = |q.ctl_a[5:4];
   assign capture_flag         = q.flag[3];
   assign compare_match_flag_b = q.flag[2];
   assign compare_match_flag_a = q.flag[1];
   assign overflow_flag        = q.flag[0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_normal_ovf_max: assert property (
      (tick && waveform_mode_sel == `STWC_MODE_NORMAL &&
       q.cnt == `STWC_TOP_MAX) |=> overflow_flag && q.cnt == 16'h0000 ||
       $past(io_wr && io_addr == `STWC_ADDR_CNT_L))
      else $error("normal mode did not wrap and flag overflow at max");
   a_fast_top_wrap: assert property (
      (tick && fast && at_top && !(io_wr && io_addr == `STWC_ADDR_CNT_L))
      |=> q.cnt == 16'h0000 && overflow_flag)
      else $error("fast pwm did not restart at top");
   a_cap_copy_cnt: assert property (
      (ev.capture_evt && !(io_wr && io_addr == `STWC_ADDR_ICR_L))
      |=> q.icr == $past(q.cnt) && capture_flag)
      else $error("capture did not copy the counter");
   a_cap_off_top: assert property (
      (icr_top && !(io_wr && io_addr == `STWC_ADDR_ICR_L)) |=> $stable(q.icr))
      else $error("capture register moved while used as top");
   a_stop_holds_cnt: assert property (
      (q.ctl_b[2:0] == 3'h0 && !(io_wr && io_addr == `STWC_ADDR_CNT_L))
      |=> $stable(q.cnt))
      else $error("stopped counter changed");
   a_force_reads_zero: assert property (
      (io_rd && io_addr == `STWC_ADDR_FORCE) |=> io_rdata == 8'h00)
      else $error("force register read non-zero");
   a_block_after_wr: assert property (
      (q.blk && tick && !(|flag_ack)) |=>
      !$rose(compare_match_flag_a) && !$rose(compare_match_flag_b))
      else $error("match flag set on tick after counter write");
   a_flag_has_cause: assert property (
      $rose(compare_match_flag_a) |-> $past(match[0]))
      else $error("compare flag a set without a counter match");
   a_buf_holds_pwm: assert property (
      (!non_pwm && !upd_now) |=> q.ocr_act == $past(q.ocr_act))
      else $error("active compare changed outside the update point");

   c_capture_seen: cover property (ev.capture_evt);
   c_phase_turn: cover property (tick && !non_pwm && !fast && at_top);
   c_force_ctc: cover property (|force_cmp &&
      waveform_mode_sel == `STWC_MODE_CTC_OCR);
   c_ext_tick: cover property (tick && q.ctl_b[2:1] == 2'b11);
endmodule

//--- bench/stwc_cpu_model.sv
// processor-side model: byte accesses on the i/o register bus
`timescale 1ns/1ps
module stwc_cpu_model
(
   input  wire logic       clk,
   input  wire logic [7:0] io_rdata,
   output logic      [5:0] io_addr,
   output logic            io_wr,
   output logic            io_rd,
   output logic      [7:0] io_wdata,
   output logic      [3:0] flag_ack
);
   // idle bus from time zero so nothing is taken during reset
   initial
   begin
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
      flag_ack = 4'h0;
   end

   // one byte write; strobe released a cycle later so calls never collide
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
      @(posedge clk);
      #1 io_wr = 1'b0;
   endtask

   // one byte read; data is registered at the strobe edge
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 {io_addr, io_rd} = {a, 1'b1};
      @(posedge clk);
      #1 io_rd = 1'b0;
      d = io_rdata;
   endtask

   // high byte goes to the shared latch first, low byte commits both
   task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
      wr(lo + 6'h01, v[15:8]);
      wr(lo, v[7:0]);
   endtask

   // low byte first so the latch holds the matching high byte
   task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 6'h01, v[15:8]);
   endtask

   // vector-executed clear pulse, one cycle wide
   task automatic ack(input logic [3:0] m);
      @(posedge clk);
      #1 flag_ack = m;
      @(posedge clk);
      #1 flag_ack = 4'h0;
   endtask
endmodule

//--- bench/sixteen_bit_timer_waveform_capture_tb.sv
// self-checking bench for the sixteen-bit timer
`timescale 1ns/1ps
`include "stwc_consts.svh"
module sixteen_bit_timer_waveform_capture_tb;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       ext_pin = 1'b0;
   logic       cap_pin = 1'b0;
   logic [5:0] io_addr;
   logic       io_wr, io_rd;
   logic [7:0] io_wdata, io_rdata, d;
   logic [3:0] flag_ack;
   logic       out_a, out_b, en_a, en_b, f_cap, f_b, f_a, f_ovf, w0;
   logic [15:0] w, v;
   int         miscompares = 0;
   int         checks = 0;
   logic [5:0] regs [8] = '{6'h2f, 6'h2e, 6'h2c, 6'h2d, 6'h2a, 6'h28,
                            6'h22, 6'h0b};

   always #2.5 clk = ~clk;

   stwc_cpu_model u_cpu (.clk(clk), .io_rdata(io_rdata),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .flag_ack(flag_ack));

   stwc_timer u_dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .flag_ack(flag_ack),
      .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
      .waveform_out_a(out_a), .waveform_out_b(out_b),
      .waveform_en_a(en_a), .waveform_en_b(en_b),
      .capture_flag(f_cap), .compare_match_flag_b(f_b),
      .compare_match_flag_a(f_a), .overflow_flag(f_ovf));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // settle several cycles, then look off the edge
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // well above the eight hundred or so cycles the sequence needs
   initial
   begin
      #100000;
      miscompares++;
      end_of_test();
   end

   initial
   begin
      hold(8);
      rst_b = 1'b1;
      foreach (regs[i])
      begin
         u_cpu.rd(regs[i], d);
         chk({8'h00, d}, 16'h0000);
      end
      // stopped clock: written value must survive idle cycles
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'h01ff);
      hold(20);
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      chk(w, 16'h01ff);
      // wrap through max with both compares on the way
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'hfff0);
      u_cpu.wr16(`STWC_ADDR_OCRA_L, 16'hfff8);
      u_cpu.wr16(`STWC_ADDR_OCRB_L, 16'h0005);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h01);
      hold(40);
      chk({f_ovf, f_a, f_b}, 3'b111);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h00);
      u_cpu.wr(`STWC_ADDR_TIFR, 8'h27);
      hold(2);
      chk({f_cap, f_ovf, f_a, f_b}, 4'h0);
      // counter write lands on the compare value; that tick is blocked
      u_cpu.wr16(`STWC_ADDR_OCRA_L, 16'h0100);
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'h0100);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h01);
      hold(10);
      chk(f_a, 1'b0);
      // falling-edge select ignores a rise, takes the fall
      cap_pin = 1'b1;
      hold(10);
      chk(f_cap, 1'b0);
      cap_pin = 1'b0;
      hold(10);
      chk(f_cap, 1'b1);
      u_cpu.ack(4'h8);
      hold(2);
      chk(f_cap, 1'b0);
      // stopped counter, rising edge: captured value equals counter
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h40);
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      cap_pin = 1'b1;
      hold(10);
      u_cpu.rd16(`STWC_ADDR_ICR_L, v);
      chk(v, w);
      chk(f_cap, 1'b1);
      // mode 1110 uses capture as top: pin is disconnected
      u_cpu.wr(`STWC_ADDR_TIFR, 8'h20);
      u_cpu.wr(`STWC_ADDR_CTL_A, 8'h02);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h58);
      cap_pin = 1'b0;
      hold(10);
      cap_pin = 1'b1;
      hold(10);
      chk(f_cap, 1'b0);
      // forced toggle on a, forced set on b in normal mode, no flag
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h00);
      u_cpu.wr(`STWC_ADDR_CTL_A, 8'h70);
      w0 = out_a;
      u_cpu.wr(`STWC_ADDR_FORCE, 8'hc0);
      hold(3);
      chk({en_a, en_b, out_a, out_b, f_a, f_b},
          {2'b11, ~w0, 3'b100});
      u_cpu.rd(`STWC_ADDR_FORCE, d);
      chk({8'h00, d}, 16'h0000);
      // external pin: rising edges only, then falling edges only
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'h0000);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h07);
      repeat (3)
      begin
         ext_pin = 1'b1;
         hold(4);
         ext_pin = 1'b0;
         hold(4);
      end
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      chk(w, 16'h0003);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h06);
      ext_pin = 1'b1;
      hold(4);
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      chk(w, 16'h0003);
      ext_pin = 1'b0;
      hold(4);
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      chk(w, 16'h0004);
      // filter on: a two-sample glitch is dropped, a steady rise is taken
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'hc0);
      cap_pin = 1'b0;
      hold(10);
      cap_pin = 1'b1;
      hold(2);
      cap_pin = 1'b0;
      hold(10);
      chk(f_cap, 1'b0);
      cap_pin = 1'b1;
      hold(10);
      chk(f_cap, 1'b1);
      // clear-on-compare with top from compare a: never reaches max
      u_cpu.wr16(`STWC_ADDR_OCRA_L, 16'h0009);
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'h0000);
      u_cpu.wr(`STWC_ADDR_TIFR, 8'h27);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h09);
      hold(40);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h08);
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      chk(w <= 16'h0009, 1'b1);
      chk({f_ovf, f_a, f_b}, 3'b011);
      // a forced strobe in that mode keeps the counter and sets no flag
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'h0003);
      u_cpu.wr(`STWC_ADDR_TIFR, 8'h27);
      u_cpu.wr(`STWC_ADDR_FORCE, 8'h80);
      u_cpu.rd16(`STWC_ADDR_CNT_L, v);
      chk(v, 16'h0003);
      chk(f_a, 1'b0);
      // fast pwm 8-bit: new compare b waits in its buffer until top
      u_cpu.wr(`STWC_ADDR_CTL_A, 8'h71);
      u_cpu.wr16(`STWC_ADDR_OCRB_L, 16'h0030);
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'h0020);
      u_cpu.wr(`STWC_ADDR_TIFR, 8'h27);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h09);
      hold(20);
      chk(f_b, 1'b0);
      hold(300);
      chk({f_ovf, f_b}, 2'b11);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h08);
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      chk(w <= 16'h00ff, 1'b1);
      // phase-and-frequency-correct, top from compare a, flag at bottom
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h10);
      u_cpu.wr16(`STWC_ADDR_CNT_L, 16'h0000);
      u_cpu.wr(`STWC_ADDR_TIFR, 8'h27);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h11);
      hold(40);
      u_cpu.wr(`STWC_ADDR_CTL_B, 8'h10);
      u_cpu.rd16(`STWC_ADDR_CNT_L, w);
      chk(w <= 16'h0009, 1'b1);
      chk(f_ovf, 1'b1);
      end_of_test();
   end
endmodule
